// File: hw/capture_match_timer.v
// 32-bit timer/counter with prescaler, two captures, four matches, apb slave
//
// How it works
// - 32-bit counter advances at a rate set by a 32-bit prescaler
// - timer mode counts pclk; counter mode counts edges of an external clock
// - two capture channels latch the count when their input transitions
// - each capture channel can separately raise the interrupt output
// - four 32-bit match registers are compared against the running count
// - match without stop or reset keeps counting; optional interrupt
// - match configured to stop halts counting; optional interrupt
// - match configured to reset clears the counter; optional interrupt
// - four match pins: low, high, toggle or unchanged on their match
// - matches 0 and 1 only can issue timed dma requests
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "capture_match_timer_regs.vh"

module capture_match_timer
(
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // external count clock and capture inputs
   input  wire        count_clk_in,
   input  wire [1:0]  capture_in,
   // match pins, dma, interrupt
   output reg  [3:0]  match_out,
   output reg  [1:0]  dma_req,
   output reg         irq
);

   // control and configuration
   reg  [31:0] ctrl_q;
   reg  [31:0] count_q;
   reg  [31:0] presc_q;
   reg  [31:0] pcount_q;
   reg  [11:0] mctrl_q;
   reg  [5:0]  cctrl_q;
   reg  [7:0]  emc_q;
   reg  [5:0]  status_q;
   reg  [1:0]  dmaen_q;
   reg  [31:0] match_q [0:3];
   reg  [31:0] cap_q   [0:1];
   reg  [2:0]  ext_sync_q;
   reg  [2:0]  cap_sync0_q;
   reg  [2:0]  cap_sync1_q;
   reg  [31:0] prev_count_q;

   wire        wr_en;
   wire        rd_en;
   wire        counting;
   wire        ext_edge;
   wire        tick;
   wire [3:0]  hit;
   wire [1:0]  cap_ev;
   wire        any_stop;
   wire        any_rst;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;

   function known_addr;
      input [11:0] a;
      begin
         known_addr = (a == `TMR_CTRL_OFS) || (a == `TMR_COUNT_OFS) ||
                      (a == `TMR_PRESC_OFS) || (a == `TMR_PCOUNT_OFS) ||
                      (a == `TMR_MCTRL_OFS) || (a == `TMR_CCTRL_OFS) ||
                      (a == `TMR_EMR_OFS) || (a == `TMR_STATUS_OFS) ||
                      (a == `TMR_DMAEN_OFS) ||
                      (a[11:4] == `TMR_MATCH0_OFS >> 4 && a[1:0] == 2'h0) ||
                      (a[11:3] == `TMR_CAP0_OFS >> 3 && a[1:0] == 2'h0);
      end
   endfunction

   // edge detect on a synchronised input: rise/fall selected by two bits
   function edge_hit;
      input [1:0] s;
      input       rise_en;
      input       fall_en;
      begin
         edge_hit = (rise_en & s[0] & ~s[1]) | (fall_en & ~s[0] & s[1]);
      end
   endfunction

   // synchronisers: stage 0 feeds stage 1 only, edges from stages 1 and 2
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_sync_q  <= 3'h0;
         cap_sync0_q <= 3'h0;
         cap_sync1_q <= 3'h0;
      end
      else
      begin
         ext_sync_q  <= {ext_sync_q[1:0], count_clk_in};
         cap_sync0_q <= {cap_sync0_q[1:0], capture_in[0]};
         cap_sync1_q <= {cap_sync1_q[1:0], capture_in[1]};
      end
   end

   // mode select
   // ext clock must be slower than pclk/2 because of the synchroniser
   assign ext_edge = edge_hit(ext_sync_q[2:1], ~ctrl_q[`CTRL_EDGE_LSB + 1],
                              ctrl_q[`CTRL_EDGE_LSB + 1]);
   // stopping match freezes count
   // without this gate the count would step once past the match value
   assign counting = ctrl_q[`CTRL_EN_BIT] & ~ctrl_q[`CTRL_RST_BIT] & ~any_stop &
                     (ctrl_q[`CTRL_MODE_BIT] ? ext_edge : 1'b1);
   assign tick = counting & (pcount_q == presc_q);

   assign cap_ev[0] = edge_hit(cap_sync0_q[2:1], cctrl_q[`CC_RISE_BIT],
                               cctrl_q[`CC_FALL_BIT]);
   assign cap_ev[1] = edge_hit(cap_sync1_q[2:1], cctrl_q[3 + `CC_RISE_BIT],
                               cctrl_q[3 + `CC_FALL_BIT]);

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_match
         // equality compare, once per new count value
         assign hit[g] = (count_q == match_q[g]) & (count_q != prev_count_q);
      end
   endgenerate

   assign any_stop = |(hit & {mctrl_q[9 + `MC_STOP_BIT], mctrl_q[6 + `MC_STOP_BIT],
                              mctrl_q[3 + `MC_STOP_BIT], mctrl_q[`MC_STOP_BIT]});
   assign any_rst  = |(hit & {mctrl_q[9 + `MC_RST_BIT], mctrl_q[6 + `MC_RST_BIT],
                              mctrl_q[3 + `MC_RST_BIT], mctrl_q[`MC_RST_BIT]});

   integer i;

   // counter, prescaler and registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q       <= `CTRL_RESET;
         count_q      <= `WORD_RESET;
         presc_q      <= `WORD_RESET;
         pcount_q     <= `WORD_RESET;
         prev_count_q <= 32'hffff_ffff;
         mctrl_q      <= 12'h000;
         cctrl_q      <= 6'h00;
         emc_q        <= 8'h00;
         dmaen_q      <= 2'h0;
         for (i = 0; i < 4; i = i + 1)
            match_q[i] <= `WORD_RESET;
         cap_q[0]     <= `WORD_RESET;
         cap_q[1]     <= `WORD_RESET;
      end
      else
      begin
         prev_count_q <= count_q;
         if (ctrl_q[`CTRL_RST_BIT])
         begin
            count_q  <= 32'h0000_0000;
            pcount_q <= 32'h0000_0000;
         end
         else if (any_rst)
         begin
            count_q  <= 32'h0000_0000;
            pcount_q <= 32'h0000_0000;
         end
         else if (tick)
         begin
            count_q  <= count_q + 32'h0000_0001;
            pcount_q <= 32'h0000_0000;
         end
         else if (counting)
            pcount_q <= pcount_q + 32'h0000_0001;

         if (cap_ev[0])
            cap_q[0] <= count_q;
         if (cap_ev[1])
            cap_q[1] <= count_q;

         if (wr_en)
         begin
            case (paddr)
               `TMR_CTRL_OFS:   ctrl_q   <= {27'h0, pwdata[4:0]};
               `TMR_COUNT_OFS:  count_q  <= pwdata;
               `TMR_PRESC_OFS:  presc_q  <= pwdata;
               `TMR_PCOUNT_OFS: pcount_q <= pwdata;
               `TMR_MCTRL_OFS:  mctrl_q  <= pwdata[11:0];
               `TMR_CCTRL_OFS:  cctrl_q  <= pwdata[5:0];
               `TMR_EMR_OFS:    emc_q    <= pwdata[7:0];
               `TMR_DMAEN_OFS:  dmaen_q  <= pwdata[1:0];
               default:
               begin
                  if (paddr[11:4] == `TMR_MATCH0_OFS >> 4 && paddr[1:0] == 2'h0)
                     match_q[paddr[3:2]] <= pwdata;
               end
            endcase
         end
         // stop clears enable unless the reset bit is set; wins over a same-cycle write
         if (any_stop & ~ctrl_q[`CTRL_RST_BIT])
            ctrl_q[`CTRL_EN_BIT] <= 1'b0;
      end
   end

   // status flags, match pins, dma, interrupt
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_q  <= 6'h00;
         match_out <= 4'h0;
         dma_req   <= 2'h0;
         irq       <= 1'b0;
      end
      else
      begin
         // match flags, set wins over write-one-to-clear
         for (i = 0; i < 4; i = i + 1)
         begin
            if (hit[i] & mctrl_q[3 * i + `MC_IRQ_BIT])
               status_q[i] <= 1'b1;
            else if (wr_en && paddr == `TMR_STATUS_OFS && pwdata[i])
               status_q[i] <= 1'b0;
         end
         for (i = 0; i < 2; i = i + 1)
         begin
            if (cap_ev[i] & cctrl_q[3 * i + `CC_IRQ_BIT])
               status_q[4 + i] <= 1'b1;
            else if (wr_en && paddr == `TMR_STATUS_OFS && pwdata[4 + i])
               status_q[4 + i] <= 1'b0;
         end
         irq <= |status_q;

         for (i = 0; i < 4; i = i + 1)
         begin
            if (hit[i])
            begin
               case (emc_q[2 * i +: 2])
                  `EM_LOW:    match_out[i] <= 1'b0;
                  `EM_HIGH:   match_out[i] <= 1'b1;
                  `EM_TOGGLE: match_out[i] <= ~match_out[i];
                  default:    match_out[i] <= match_out[i];
               endcase
            end
         end

         // dma pulse from matches 0 and 1 only
         dma_req <= hit[1:0] & dmaen_q;
      end
   end

   // apb read and answer: zero wait states
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~known_addr(paddr);
         prdata  <= 32'h0000_0000;
         if (psel & ~penable & ~pwrite)
         begin
            case (paddr)
               `TMR_CTRL_OFS:   prdata <= ctrl_q;
               `TMR_COUNT_OFS:  prdata <= count_q;
               `TMR_PRESC_OFS:  prdata <= presc_q;
               `TMR_PCOUNT_OFS: prdata <= pcount_q;
               `TMR_MCTRL_OFS:  prdata <= {20'h0, mctrl_q};
               `TMR_CCTRL_OFS:  prdata <= {26'h0, cctrl_q};
               `TMR_EMR_OFS:    prdata <= {20'h0, match_out, emc_q};
               `TMR_STATUS_OFS: prdata <= {26'h0, status_q};
               `TMR_DMAEN_OFS:  prdata <= {30'h0, dmaen_q};
               default:
               begin
                  if (paddr[11:4] == `TMR_MATCH0_OFS >> 4 && paddr[1:0] == 2'h0)
                     prdata <= match_q[paddr[3:2]];
                  else if (paddr[11:3] == `TMR_CAP0_OFS >> 3 && paddr[1:0] == 2'h0)
                     prdata <= cap_q[paddr[2]];
               end
            endcase
         end
      end
   end

   // rd_en kept for symmetry of decode; read data is taken in setup
   wire unused_rd = rd_en;

endmodule // capture_match_timer

// File: hw/capture_match_timer_regs.vh
// register offsets, fields and reset values of the capture/match timer
`ifndef CAPTURE_MATCH_TIMER_REGS_VH
`define CAPTURE_MATCH_TIMER_REGS_VH

// register byte offsets
`define TMR_CTRL_OFS     12'h000
`define TMR_COUNT_OFS    12'h004
`define TMR_PRESC_OFS    12'h008
`define TMR_PCOUNT_OFS   12'h00c
`define TMR_MCTRL_OFS    12'h010
`define TMR_CCTRL_OFS    12'h014
`define TMR_EMR_OFS      12'h018
`define TMR_STATUS_OFS   12'h01c
`define TMR_DMAEN_OFS    12'h020
`define TMR_MATCH0_OFS   12'h040
`define TMR_CAP0_OFS     12'h050

// control register fields
`define CTRL_EN_BIT      0
`define CTRL_RST_BIT     1
`define CTRL_MODE_BIT    2
`define CTRL_EDGE_LSB    3

// match control: three bits per match (irq, reset, stop)
`define MC_IRQ_BIT       0
`define MC_RST_BIT       1
`define MC_STOP_BIT      2

// capture control: three bits per channel (rise, fall, irq)
`define CC_RISE_BIT      0
`define CC_FALL_BIT      1
`define CC_IRQ_BIT       2

// external match output actions
`define EM_NONE          2'h0
`define EM_LOW           2'h1
`define EM_HIGH          2'h2
`define EM_TOGGLE        2'h3

// reset values
`define CTRL_RESET       32'h0000_0000
`define WORD_RESET       32'h0000_0000

`endif

// File: verification/timer_checks_assertions.sv
// port checks for the capture/match timer
`timescale 1ns/100ps
module timer_checks
(
   // apb
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // pins
   input wire [3:0]  match_out,
   input wire [1:0]  dma_req,
   input wire        irq
);
   logic pins_q;
   logic dma_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // pins and dma stay quiet until configured
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pins_q <= 1'b0;
         dma_q  <= 1'b0;
      end
      else if (psel && penable && pwrite)
      begin
         pins_q <= pins_q | (paddr == 12'h018);
         dma_q  <= dma_q | (paddr == 12'h020);
      end
   property p_rdy;
      pready |-> penable && $past(psel && !penable);
   endproperty
   a_rdy: assert property (p_rdy) else $error("pready outside access");
   property p_once;
      pready |=> !pready;
   endproperty
   a_once: assert property (p_once) else $error("pready too long");
   property p_err;
      pslverr && !pwrite |-> pready && prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("bad refused read");
   property p_dma;
      (dma_req & $past(dma_req)) == 2'h0;
   endproperty
   a_dma: assert property (p_dma) else $error("dma not a pulse");
   property p_dma_en;
      dma_req != 2'h0 |-> dma_q;
   endproperty
   a_dma_en: assert property (p_dma_en) else $error("dma unasked");
   property p_pin;
      match_out != 4'h0 |-> pins_q;
   endproperty
   a_pin: assert property (p_pin) else $error("pin moved unasked");
   property p_irq;
      $fell(irq) |-> $past(psel && penable && pwrite && paddr == 12'h01c, 2);
   endproperty
   a_irq: assert property (p_irq) else $error("irq fell unasked");
endmodule // timer_checks
bind capture_match_timer timer_checks i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .match_out(match_out), .dma_req(dma_req), .irq(irq));

// File: verification/ext_pins.sv
// far-side model: count clock and capture pins
`timescale 1ns/100ps
module ext_pins
(
   input  wire       pclk,
   output reg        count_clk_in,
   output reg  [1:0] capture_in
);
   initial
   begin
      count_clk_in = 1'b0;
      capture_in   = 2'h0;
   end
   task clk_pulses(input int n);
      repeat (n)
      begin
         repeat (3) @(posedge pclk);
         count_clk_in <= 1'b1;
         repeat (3) @(posedge pclk);
         count_clk_in <= 1'b0;
      end
   endtask
   task set_cap(input logic [1:0] v);
      repeat (4) @(posedge pclk);
      capture_in <= v;
   endtask
endmodule // ext_pins

// File: verification/tb_top.sv
// self-checking bench for the capture/match timer
`timescale 1ns/100ps
module tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rdat;
   logic        rerr;
   wire  [31:0] prdata;
   wire         pready, pslverr, count_clk_in, irq;
   wire  [1:0]  capture_in, dma_req;
   wire  [3:0]  match_out;
   int          miscompares = 0, n_tests = 0, n_dma = 0, d0;
   always #25 pclk = ~pclk;
   always @(posedge pclk) n_dma <= n_dma + dma_req[0] + dma_req[1];
   capture_match_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .count_clk_in(count_clk_in),
      .capture_in(capture_in), .match_out(match_out), .dma_req(dma_req), .irq(irq));
   ext_pins i_ext (.pclk(pclk), .count_clk_in(count_clk_in), .capture_in(capture_in));
   task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      repeat (16) if (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      chk("pready", pready, 33'h1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task t_regs;
      apb(1'b1, 12'h044, 32'ha5a5_0003);
      apb(1'b0, 12'h044, 32'h0);
      chk("match reg", rdat, 33'ha5a5_0003);
      apb(1'b0, 12'h0fc, 32'h0);
      chk("unmapped", {rerr, rdat}, 33'h1_0000_0000);
   endtask
   task run(input logic [31:0] emr, input logic [31:0] mc);
      apb(1'b1, 12'h000, 32'h2);
      apb(1'b1, 12'h010, mc);
      apb(1'b1, 12'h018, emr);
      d0 = n_dma;
      apb(1'b1, 12'h000, 32'h1);
      repeat (30) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
   endtask
   task t_match;
      apb(1'b1, 12'h040, 32'h1);
      apb(1'b1, 12'h044, 32'h2);
      apb(1'b1, 12'h048, 32'h3);
      apb(1'b1, 12'h04c, 32'hffff);
      apb(1'b1, 12'h020, 32'h3);
      run(32'h2e, 32'h100);
      chk("stop", rdat, 33'h3);
      chk("pins", match_out, 33'h7);
      chk("dma", n_dma - d0, 33'h2);
      run(32'h0d, 32'h100);
      chk("pins", match_out, 33'h4);
      run(32'h0, 32'h80);
      chk("wrap", rdat <= 3, 33'h1);
      chk("dma", n_dma - d0 > 4, 33'h1);
   endtask
   task t_count;
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b1, 12'h010, 32'h0);
      apb(1'b1, 12'h000, 32'h6);
      apb(1'b1, 12'h000, 32'h5);
      i_ext.clk_pulses(6);
      repeat (6) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      chk("ext count", rdat, 33'h3);
      apb(1'b1, 12'h014, 32'h15);
      apb(1'b1, 12'h01c, 32'h3f);
      i_ext.set_cap(2'h3);
      i_ext.set_cap(2'h0);
      repeat (6) @(posedge pclk);
      apb(1'b1, 12'h050, 32'h9);
      apb(1'b0, 12'h050, 32'h0);
      chk("cap0", rdat, 33'h3);
      apb(1'b0, 12'h054, 32'h0);
      chk("cap1", rdat, 33'h3);
      chk("irq", irq, 33'h1);
      apb(1'b1, 12'h01c, 32'h3f);
      repeat (3) @(posedge pclk);
      chk("irq", irq, 33'h0);
   endtask
   task conclude;
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_match;
      t_count;
      conclude;
   end
   initial
   begin
      #200000;
      miscompares++;
      conclude;
   end
endmodule // tb_top
